// >>> rtl/fo_pkg.sv
// constants and types for the outer decoder and output formatter
// Contract
// - deinterleave bit set: deinterleave bytes; clear: pass unchanged
// - sync search clear: no sync search, byte grouping phase stays fixed
// - correction clear: no correction, all data to descrambler, error low
// - descramble control set: descramble decoder output; clear: bypass it
// - error marking: uncorrectable packet sets MSB of byte after sync
// - sync forcing set: first byte of each packet becomes 0x47
// - sync forcing clear: first byte passes as received
// - polarity bit picks falling or rising output clock launch edge
// - parity gating: data and error zero, parallel clock low in parity
// - parity gating: bad packet raises error only over data bytes
// - no gating: clock continuous, parity sent, error whole bad packet
// - error mode bit one gives count, zero gives rate
// - two-bit source field selects which error events are counted
// - period field sets 2^12, 2^14, 2^16 or 2^18 bytes
package fo_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OUTER_CTRL = 8'h33;
    localparam logic [7:0] ADDR_ERR_CFG = 8'h34;
    localparam logic [7:0] RST_OUTER_CTRL = 8'hF8;
    localparam logic [7:0] RST_ERR_CFG = 8'h01;
    localparam int BIT_DEINT = 7;
    localparam int BIT_SEARCH = 6;
    localparam int BIT_CORR = 5;
    localparam int BIT_DESCR = 4;
    localparam int BIT_MARK = 3;
    localparam int BIT_FORCE = 2;
    localparam int BIT_POL = 1;
    localparam int BIT_GATE = 0;
    localparam int BIT_ERR_MODE = 7;
    localparam int SRC_LSB = 4;
    localparam int PER_LSB = 0;
    localparam logic [7:0] ERR_CFG_MASK = 8'hB3;
    // ------------------------------------------------------------
    // packet framing
    // ------------------------------------------------------------
    localparam logic [7:0] SYNC_BYTE = 8'h47;
    localparam logic [7:0] SYNC_INV = 8'hB8;
    localparam logic [7:0] PKT_LEN = 8'hCC;
    localparam logic [7:0] DATA_LEN = 8'hBC;
    localparam logic [14:0] PRBS_INIT = 15'h00A9;
    localparam int DI_BRANCHES = 12;
    localparam int DI_UNIT = 17;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int OUT_CLK_PERIOD_NS = 125;
    localparam int OUT_HALF_CYC = OUT_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int PER_EXP0 = 12;
    localparam int PER_EXP1 = 14;
    localparam int PER_EXP2 = 16;
    localparam int PER_EXP3 = 18;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] fix;
        logic uncorr;
    } fo_in_s;
    typedef struct packed {
        logic [7:0] data;
        logic err;
        logic park;
    } fo_out_s;
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_FIRST = 3'b010,
        S_SECOND = 3'b100
    } fo_state_e;
endpackage

// >>> rtl/fo_outer_output.sv
// outer decoder control, output formatter and byte fifo
`timescale 1ns/1ps
module fo_fifo import fo_pkg::*; #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic push;
    logic pop;
    assign wr_ready = (cnt != DEPTH[AW:0]);
    assign rd_valid = (cnt != '0);
    assign rd_data = mem[rp];
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp] <= wr_data;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module fo_outer_output import fo_pkg::*; #(
    parameter int FIFO_DEPTH = 4,
    parameter int PER_EXP_0 = PER_EXP0,
    parameter int PER_EXP_1 = PER_EXP1,
    parameter int PER_EXP_2 = PER_EXP2,
    parameter int PER_EXP_3 = PER_EXP3
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire fo_in_s in_byte,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic serial_mode,
    input wire logic [3:0] err_evt,
    output logic [7:0] out_data,
    output logic out_err,
    output logic out_clk,
    output logic sync_locked,
    output logic [19:0] err_result,
    output logic err_result_valid
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] outer_decoder_control;
    logic [7:0] error_counter_config;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            outer_decoder_control <= RST_OUTER_CTRL;
            error_counter_config <= RST_ERR_CFG;
            reg_rdata <= '0;
        end else begin
            if (reg_wr && reg_addr == ADDR_OUTER_CTRL) begin
                outer_decoder_control <= reg_wdata;
            end
            if (reg_wr && reg_addr == ADDR_ERR_CFG) begin
                error_counter_config <= reg_wdata & ERR_CFG_MASK;
            end
            case (reg_addr)
                ADDR_OUTER_CTRL: reg_rdata <= outer_decoder_control;
                ADDR_ERR_CFG: reg_rdata <= error_counter_config;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
    logic deinterleave_enable;
    logic sync_search_enable;
    logic correction_enable;
    logic descramble_enable;
    logic error_mark_enable;
    logic sync_force_enable;
    logic out_clock_polarity;
    logic parity_gating;
    logic [1:0] count_period_sel;
    assign deinterleave_enable = outer_decoder_control[BIT_DEINT];
    assign sync_search_enable = outer_decoder_control[BIT_SEARCH];
    assign correction_enable = outer_decoder_control[BIT_CORR];
    assign descramble_enable = outer_decoder_control[BIT_DESCR];
    assign error_mark_enable = outer_decoder_control[BIT_MARK];
    assign sync_force_enable = outer_decoder_control[BIT_FORCE];
    assign out_clock_polarity = outer_decoder_control[BIT_POL];
    assign parity_gating = outer_decoder_control[BIT_GATE];
    assign count_period_sel = error_counter_config[PER_LSB +: 2];
    // ------------------------------------------------------------
    // framing and sync search
    // ------------------------------------------------------------
    logic take;
    logic [7:0] pos;
    logic [3:0] branch;
    logic is_sync;
    assign take = in_valid && in_ready;
    assign is_sync = (in_byte.data == SYNC_BYTE) || (in_byte.data == SYNC_INV);
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pos <= '0;
            sync_locked <= 1'b0;
        end else if (take) begin
            if (sync_search_enable && !sync_locked && is_sync) begin
                pos <= 8'd1;
            end else begin
                pos <= (pos == PKT_LEN - 1'b1) ? 8'd0 : pos + 1'b1;
            end
            if (!sync_search_enable) begin
                sync_locked <= 1'b0;
            end else if (pos == 8'd0) begin
                sync_locked <= is_sync;
            end else if (is_sync && !sync_locked) begin
                sync_locked <= 1'b1;
            end
        end
    end
    assign branch = 4'(pos % DI_BRANCHES);
    // ------------------------------------------------------------
    // convolutional deinterleaver
    // ------------------------------------------------------------
    // branch j delays by (branches-1-j) units; ram is large but simple
    localparam int DI_DEPTH = (DI_BRANCHES - 1) * DI_UNIT;
    // last branch has no delay, so it needs no storage
    logic [7:0] di_mem [DI_BRANCHES - 1][DI_DEPTH];
    logic [7:0] di_ptr [DI_BRANCHES - 1];
    logic [7:0] di_byte;
    genvar gj;
    generate
        for (gj = 0; gj < DI_BRANCHES - 1; gj++) begin : g_branch
            localparam logic [7:0] LEN = 8'((DI_BRANCHES - 1 - gj) * DI_UNIT);
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    di_ptr[gj] <= '0;
                end else if (take && branch == 4'(gj)) begin
                    di_mem[gj][di_ptr[gj]] <= in_byte.data;
                    di_ptr[gj] <= (di_ptr[gj] == LEN - 1'b1) ? '0
                                  : di_ptr[gj] + 1'b1;
                end
            end
        end
    endgenerate
    always_comb begin
        if (!deinterleave_enable || branch == 4'(DI_BRANCHES - 1)) begin
            di_byte = in_byte.data;
        end else begin
            di_byte = di_mem[branch][di_ptr[branch]];
        end
    end
    // ------------------------------------------------------------
    // correction, descrambler, marking
    // ------------------------------------------------------------
    function automatic logic [22:0] prbs_step(input logic [14:0] r);
        logic [14:0] s;
        logic [7:0] b;
        logic nb;
        s = r;
        b = '0;
        for (int k = 7; k >= 0; k--) begin
            nb = s[13] ^ s[14];
            b[k] = nb;
            s = {s[13:0], nb};
        end
        return {s, b};
    endfunction
    logic [14:0] prbs;
    logic [22:0] prbs_nx;
    logic is_parity;
    logic [7:0] cbyte;
    logic bad_pkt;
    fo_out_s fw;
    assign prbs_nx = prbs_step(prbs);
    assign is_parity = (pos >= DATA_LEN);
    assign bad_pkt = correction_enable && in_byte.uncorr;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            prbs <= PRBS_INIT;
        end else if (take) begin
            if (pos == 8'd0 && di_byte == SYNC_INV) begin
                prbs <= PRBS_INIT;
            end else if (!is_parity) begin
                prbs <= prbs_nx[22:8];
            end
        end
    end
    always_comb begin
        cbyte = correction_enable ? (di_byte ^ in_byte.fix) : di_byte;
        if (descramble_enable && pos != 8'd0 && !is_parity) begin
            cbyte = cbyte ^ prbs_nx[7:0];
        end
        if (error_mark_enable && bad_pkt && pos == 8'd1) begin
            cbyte[7] = 1'b1;
        end
        if (sync_force_enable && pos == 8'd0) begin
            cbyte = SYNC_BYTE;
        end
        fw.data = cbyte;
        // error over whole packet when not gated
        fw.err = bad_pkt;
        fw.park = 1'b0;
        if (parity_gating && is_parity) begin
            fw.data = '0;
            fw.err = 1'b0;
            fw.park = !serial_mode;
        end
    end
    // ------------------------------------------------------------
    // output fifo and launcher
    // ------------------------------------------------------------
    localparam int OCC_W = $clog2(FIFO_DEPTH) + 1;
    fo_out_s rw;
    logic rvalid;
    logic pop;
    logic [OCC_W-1:0] occ;
    logic [OCC_W-1:0] next_occ;
    fo_fifo #(.WIDTH($bits(fo_out_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .wr_data(fw),
        .wr_valid(take),
        .wr_ready(),
        .rd_data(rw),
        .rd_valid(rvalid),
        .rd_ready(pop)
    );
    fo_state_e st;
    logic [7:0] half;
    logic parked;
    assign pop = (st == S_IDLE) && rvalid;
    // fill mirror lets in_ready come from a flop, one cycle ahead
    assign next_occ = occ + OCC_W'(take) - OCC_W'(pop);
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            occ <= '0;
            in_ready <= 1'b1;
        end else begin
            occ <= next_occ;
            in_ready <= (next_occ != OCC_W'(FIFO_DEPTH));
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= S_IDLE;
            half <= '0;
            parked <= 1'b0;
            out_data <= '0;
            out_err <= 1'b0;
            out_clk <= 1'b0;
        end else begin
            case (st)
                S_IDLE: begin
                    out_clk <= out_clock_polarity;
                    if (rvalid) begin
                        // data changes with the launch edge
                        out_data <= rw.data;
                        out_err <= rw.err;
                        parked <= rw.park;
                        out_clk <= rw.park ? 1'b0 : !out_clock_polarity;
                        half <= 8'(OUT_HALF_CYC - 1);
                        st <= S_FIRST;
                    end
                end
                S_FIRST: begin
                    half <= half - 1'b1;
                    if (half == 8'd0) begin
                        // parallel clock held low in parity
                        out_clk <= parked ? 1'b0 : out_clock_polarity;
                        half <= 8'(OUT_HALF_CYC - 2);
                        st <= S_SECOND;
                    end
                end
                S_SECOND: begin
                    half <= half - 1'b1;
                    if (half == 8'd0) begin
                        st <= S_IDLE;
                    end
                end
                default: st <= S_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // error counter
    // ------------------------------------------------------------
    logic [19:0] ecnt;
    logic [18:0] per_cnt;
    logic [18:0] per_last;
    logic evt;
    always_comb begin
        case (count_period_sel)
            2'b00: per_last = 19'((1 << PER_EXP_0) - 1);
            2'b01: per_last = 19'((1 << PER_EXP_1) - 1);
            2'b10: per_last = 19'((1 << PER_EXP_2) - 1);
            default: per_last = 19'((1 << PER_EXP_3) - 1);
        endcase
    end
    assign evt = err_evt[error_counter_config[SRC_LSB +: 2]];
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ecnt <= '0;
            per_cnt <= '0;
            err_result <= '0;
            err_result_valid <= 1'b0;
        end else begin
            err_result_valid <= 1'b0;
            if (error_counter_config[BIT_ERR_MODE]) begin
                if (evt && ecnt != '1) begin
                    ecnt <= ecnt + 1'b1;
                end
                err_result <= ecnt;
                per_cnt <= '0;
            end else if (pop) begin
                if (per_cnt >= per_last) begin
                    per_cnt <= '0;
                    err_result <= ecnt + 20'(evt);
                    err_result_valid <= 1'b1;
                    ecnt <= '0;
                end else begin
                    per_cnt <= per_cnt + 1'b1;
                    ecnt <= ecnt + 20'(evt);
                end
            end else if (evt) begin
                ecnt <= ecnt + 1'b1;
            end
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_force_sync: assert property (
        take && sync_force_enable && pos == 8'd0 |-> fw.data == SYNC_BYTE)
        else $error("forced sync byte wrong");
    a_pass_sync: assert property (
        take && !sync_force_enable && pos == 8'd0 && !parity_gating
        |-> fw.data == (correction_enable ? di_byte ^ in_byte.fix : di_byte))
        else $error("received sync altered");
    a_corr_off_err: assert property (
        take && !correction_enable |-> !fw.err)
        else $error("error flagged without correction");
    a_mark_msb: assert property (
        take && error_mark_enable && bad_pkt && pos == 8'd1
        && !(parity_gating && is_parity) |-> fw.data[7])
        else $error("error mark missing");
    a_gate_parity: assert property (
        take && parity_gating && is_parity |-> fw.data == '0 && !fw.err
        && fw.park == !serial_mode)
        else $error("parity byte not gated");
    a_gate_data_err: assert property (
        take && parity_gating && bad_pkt && !is_parity |-> fw.err)
        else $error("error missing on data byte");
    a_whole_pkt_err: assert property (
        take && !parity_gating && bad_pkt |-> fw.err && !fw.park)
        else $error("error not held over packet");
    a_launch_edge: assert property (
        pop && !rw.park |=> out_clk == !$past(out_clock_polarity)
        && out_data == $past(rw.data))
        else $error("launch edge wrong");
    a_half_clock: assert property (
        st == S_FIRST && half == 8'd0 && !parked
        |=> out_clk == $past(out_clock_polarity))
        else $error("second half level wrong");
    a_rate_period: assert property (
        err_result_valid |-> $past(per_cnt) == $past(per_last))
        else $error("rate period length wrong");
    a_fixed_phase: assert property (
        take && !sync_search_enable |=>
        pos == (($past(pos) == PKT_LEN - 1'b1) ? 8'd0 : $past(pos) + 1'b1))
        else $error("phase moved with search off");
    a_bypass_path: assert property (
        take && !deinterleave_enable && !descramble_enable
        && !correction_enable && pos > 8'd1 && !parity_gating
        |-> fw.data == in_byte.data)
        else $error("bypassed byte altered");
endmodule

// >>> test/fo_demux_model.sv
// packet demultiplexer model capturing formatter output bytes
`timescale 1ns/1ps
module fo_demux_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic out_clk,
    input wire logic [7:0] out_data,
    input wire logic out_err,
    input wire logic pol,
    output logic rx_stb,
    output logic [7:0] rx_data,
    output logic rx_err
);
    logic clk_q;
    // sample on opposite edge
    // mid-byte sampling, away from the launch edge
    always_ff @(posedge core_clk) begin
        clk_q <= out_clk;
        rx_stb <= rstn && (out_clk !== clk_q) && (out_clk === pol);
        rx_data <= out_data;
        rx_err <= out_err;
    end
endmodule

// >>> test/tb_top.sv
// testbench for outer decoder control and output formatter
`timescale 1ns/1ps
module tb_top import fo_pkg::*;;
    logic core_clk, rstn, reg_wr, in_valid, in_ready, serial_mode, pol;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, out_data, rx_data;
    logic out_err, out_clk, sync_locked, err_result_valid, rx_stb, rx_err;
    logic [3:0] err_evt;
    logic [19:0] err_result;
    fo_in_s in_byte;
    logic [8:0] got_q[$];
    int failures, n_checks;

    fo_outer_output #(.PER_EXP_0(2), .PER_EXP_1(3), .PER_EXP_2(4),
        .PER_EXP_3(5)) dut_u (.core_clk(core_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .in_byte(in_byte), .in_valid(in_valid),
        .in_ready(in_ready), .serial_mode(serial_mode), .err_evt(err_evt),
        .out_data(out_data), .out_err(out_err), .out_clk(out_clk),
        .sync_locked(sync_locked), .err_result(err_result),
        .err_result_valid(err_result_valid));
    fo_demux_model rx_u (.core_clk(core_clk), .rstn(rstn),
        .out_clk(out_clk), .out_data(out_data), .out_err(out_err),
        .pol(pol), .rx_stb(rx_stb), .rx_data(rx_data), .rx_err(rx_err));

    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (rx_stb === 1'b1) begin
            got_q.push_back({rx_err, rx_data});
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [19:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic reg_wr_t(input logic [7:0] a, d);
        tick(1);
        reg_addr = a;
        reg_wr = 1'b1;
        reg_wdata = d;
        tick(1);
        reg_wr = 1'b0;
    endtask
    task automatic reg_rd_t(input logic [7:0] a, output logic [7:0] d);
        tick(1);
        reg_addr = a;
        tick(1);
        d = reg_rdata;
    endtask
    task automatic send_pkt(input logic [7:0] first, input logic unc);
        for (int p = 0; p < 204; p++) begin
            in_byte.data = (p == 0) ? first : 8'(p);
            in_byte.fix = (p == 5) ? 8'h5A : 8'h00;
            in_byte.uncorr = unc;
            in_valid = 1'b1;
            while (in_ready !== 1'b1) tick(1);
            tick(1);
        end
        in_valid = 1'b0;
    endtask
    task automatic wait_valid(output int cyc);
        cyc = 0;
        do begin
            tick(1);
            cyc++;
        end while (err_result_valid !== 1'b1 && cyc < 3000);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_regs();
        logic [7:0] d;
        reg_rd_t(ADDR_OUTER_CTRL, d);
        chk("ctrl reset", 20'(d), 20'(RST_OUTER_CTRL));
        reg_rd_t(ADDR_ERR_CFG, d);
        chk("cfg reset", 20'(d), 20'(RST_ERR_CFG));
        // reserved bits written one on purpose, must read zero
        reg_wr_t(ADDR_ERR_CFG, 8'hFF);
        reg_rd_t(ADDR_ERR_CFG, d);
        chk("cfg mask", 20'(d), 20'h000B3);
        reg_wr_t(8'h35, 8'hFF);
        reg_rd_t(8'h35, d);
        chk("unmapped", 20'(d), 20'h00000);
        reg_wr_t(ADDR_OUTER_CTRL, 8'h5A);
        reg_rd_t(ADDR_OUTER_CTRL, d);
        chk("ctrl rw", 20'(d), 20'h0005A);
    endtask
    // one packet through; expected stream built from control bits
    task automatic run_pkt(input logic [7:0] ctrl, input logic ser,
                           input logic [7:0] first, input logic unc);
        logic gate, park, par, e;
        logic [7:0] d;
        int n, k;
        gate = ctrl[BIT_GATE];
        park = gate && !ser;
        reg_wr_t(ADDR_OUTER_CTRL, ctrl);
        serial_mode = ser;
        pol = ctrl[BIT_POL];
        // idle level may flip with polarity: drop that stray edge
        tick(40);
        got_q.delete();
        send_pkt(first, unc);
        n = park ? 188 : 204;
        for (k = 0; k < 400 && got_q.size() < n; k++) tick(1);
        chk("byte count", 20'(got_q.size()), 20'(n));
        k = 0;
        for (int p = 0; p < 204; p++) begin
            par = (p >= 188);
            if (par && park) continue;
            d = (p == 0) ? (ctrl[BIT_FORCE] ? SYNC_BYTE : first) : 8'(p);
            if (ctrl[BIT_CORR] && p == 5) d = d ^ 8'h5A;
            if (p == 1 && ctrl[BIT_MARK] && ctrl[BIT_CORR] && unc) begin
                d[7] = 1'b1;
            end
            if (par && gate) d = 8'h00;
            e = ctrl[BIT_CORR] && unc && !(par && gate);
            if (k < got_q.size())
                chk("out byte", 20'(got_q[k]), 20'({e, d}));
            k++;
        end
    endtask
    task automatic sc_rate();
        int cyc, per;
        reg_wr_t(ADDR_OUTER_CTRL, 8'h00);
        for (int s = 0; s < 4; s++) begin
            reg_wr_t(ADDR_ERR_CFG, {2'b00, 2'(s), 2'b00, 2'(s)});
            fork
                send_pkt(SYNC_BYTE, 1'b0);
            join_none
            wait_valid(cyc);
            wait_valid(cyc);
            err_evt = 4'hF;
            tick(1);
            err_evt = 4'(1 << s);
            tick(s + 1);
            err_evt = 4'h0;
            wait_valid(cyc);
            // event pulses above used s + 2 cycles of this period
            per = (2 * OUT_HALF_CYC << (s + 2)) - s - 2;
            chk("rate period", 20'(cyc), 20'(per));
            chk("rate value", err_result, 20'(s + 2));
            wait fork;
        end
    endtask
    task automatic sc_count();
        logic [19:0] base;
        reg_wr_t(ADDR_ERR_CFG, 8'h80);
        tick(4);
        base = err_result;
        err_evt = 4'h1;
        tick(3);
        err_evt = 4'h0;
        tick(4);
        chk("count value", err_result, base + 20'h00003);
    endtask

    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        in_byte = '0;
        in_valid = 1'b0;
        serial_mode = 1'b0;
        err_evt = 4'h0;
        pol = 1'b0;
        failures = 0;
        n_checks = 0;
        tick(2);
        rstn = 1'b1;
        sc_regs();
        run_pkt(8'h04, 1'b0, 8'h00, 1'b1);
        run_pkt(8'h02, 1'b0, SYNC_INV, 1'b0);
        run_pkt(8'h29, 1'b0, SYNC_BYTE, 1'b1);
        run_pkt(8'h21, 1'b1, SYNC_BYTE, 1'b1);
        run_pkt(8'h20, 1'b0, SYNC_BYTE, 1'b1);
        chk("lock off", 20'(sync_locked), 20'h00000);
        run_pkt(8'h60, 1'b0, SYNC_BYTE, 1'b1);
        chk("lock on", 20'(sync_locked), 20'h00001);
        sc_rate();
        sc_count();
        tally_and_finish();
    end
    // a hang counts as a mismatch
    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end
endmodule
